// >>> hw/atf_pkg.sv
// Purpose: Types shared by the task file decode block.
// Assumes: Included header holds the numbers.
// Notes:   Types only.
package atf_pkg;
  typedef enum logic [1:0] {
    ATF_SEL_NONE = 2'b00,
    ATF_SEL_CMD  = 2'b01,
    ATF_SEL_CTL  = 2'b10,
    ATF_SEL_BAD  = 2'b11
  } atf_sel_t;
  typedef enum logic [1:0] {
    ATF_ST_IDLE  = 2'b00,
    ATF_ST_RD    = 2'b01,
    ATF_ST_WR    = 2'b10
  } atf_state_t;
endpackage

// >>> hw/atf_regs.svh
// Purpose: Offsets, field positions and reset values.
// Assumes: Included by the task file decode module.
// Notes:   Definitions only.
`ifndef ATF_REGS_SVH
`define ATF_REGS_SVH
// Command block offsets (command block select asserted).
`define ATF_OFS_DATA      3'h0
`define ATF_OFS_ERRFEAT   3'h1
`define ATF_OFS_SECCNT    3'h2
`define ATF_OFS_SECNUM    3'h3
`define ATF_OFS_CYLLO     3'h4
`define ATF_OFS_CYLHI     3'h5
`define ATF_OFS_DEVHEAD   3'h6
`define ATF_OFS_STATCMD   3'h7
// Control block offsets (control block select asserted).
`define ATF_OFS_ALTCTL    3'h6
`define ATF_OFS_DRVADDR   3'h7
// Device control fields.
`define ATF_DC_RESET      2
`define ATF_DC_IDIS       1
// Device/head fields.
`define ATF_DH_LBA        6
`define ATF_DH_DEV        4
// Status fields.
`define ATF_ST_DREQ       3
// Drive address readback fields.
`define ATF_DA_FLOAT      7
`define ATF_DA_WGATE      6
// Register reset values.
`define ATF_RST_SECCNT    8'h01
`define ATF_RST_SECNUM    8'h01
`define ATF_RST_CYLLO     8'h00
`define ATF_RST_CYLHI     8'h00
`define ATF_RST_DEVHEAD   8'hA0
`define ATF_RST_FEAT      8'h00
`define ATF_RST_DCTL      8'h00
`endif

// >>> hw/atf_strobe_sync.sv
// Purpose: Two-stage synchroniser for host pins and host data lines.
// Assumes: Inputs are asynchronous to clk_in.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module atf_strobe_sync #(
  parameter int W = 8
) (
  // Clock and control
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         ce_in,
  // Pins
  input  wire logic [W-1:0] async_in,
  // Synchronised
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else if (ce_in) begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule // atf_strobe_sync
`default_nettype wire

// >>> hw/atf_task_file.sv
// Purpose: Task file register decode of a parallel disk interface device.
// Assumes: Host pins are asynchronous; the drive core runs on clk_in.
// Notes:   Bus access completes on the strobe release seen after sync.
`timescale 1ns/10ps
`default_nettype none
`include "atf_regs.svh"
// What this block does
// - With the jumper fitted, cable select low makes master; open or high makes slave.
// - With no jumper fitted the device acts as master.
// - Command select picks command block, control select picks control block.
// - Command reads 0..7: data, error, count, sector, cyl lo/hi, dh, status.
// - Command writes 0..7: data, features, count, sector, cyl, dh, command.
// - Control offset 6 is alt status/device control, 7 drive address.
// - No select or both selects: bus floats, writes ignored.
// - LBA bits map to sector, cylinder low, cylinder high, head field.
// - At command end cylinder registers take the current cylinder or LBA.
// - Alternate status mirrors status without acknowledging interrupts.
// - A command register write starts the command immediately.
// - Data transfers are 16 bits, ECC bytes 8 bits, PIO only.
// - Data register holds valid data only while data request is set.
// - Soft reset bit set holds the device in reset; clearing releases.
// - Interrupts enabled only when disable bit is zero and selected.
// - Top bit of drive address register is never driven.
// - Write gate bit reads zero while disk write is in progress.
// - Inverted head bits are the complement of the selected head.
// - Low two bits are active-low slave and master selected flags.
// - Device select bit zero targets master, one targets slave.
// - Status register read acknowledges and clears pending interrupt.
// - Address mode bit zero is CHS, one is LBA.
module atf_task_file
  import atf_pkg::*;
(
  // Clock and control
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  // Host pins
  input  wire logic        command_block_select_n_in,
  input  wire logic        control_block_select_n_in,
  input  wire logic [2:0]  register_address_lines_in,
  input  wire logic        host_read_strobe_n_in,
  input  wire logic        host_write_strobe_n_in,
  input  wire logic [15:0] host_data_in,
  output logic      [15:0] host_data_out,
  output logic      [15:0] host_data_oe_out,
  output logic             host_intrq_out,
  // Drive address straps
  input  wire logic        jumper_fitted_in,
  input  wire logic        cable_select_in,
  // Drive core side
  input  wire logic [7:0]  core_status_in,
  input  wire logic [7:0]  core_error_in,
  input  wire logic [15:0] core_rd_data_in,
  input  wire logic        core_byte_mode_in,
  input  wire logic        core_irq_in,
  input  wire logic        core_done_in,
  input  wire logic [7:0]  core_sector_in,
  input  wire logic [15:0] core_cyl_in,
  input  wire logic [3:0]  core_head_in,
  input  wire logic        core_disk_write_in,
  output logic             core_rd_pop_out,
  output logic             core_wr_push_out,
  output logic [15:0]      core_wr_data_out,
  output logic             cmd_start_out,
  output logic [7:0]       cmd_code_out,
  output logic [7:0]       features_out,
  output logic [7:0]       sector_count_out,
  output logic             lba_mode_out,
  output logic [27:0]      lba_out,
  output logic             device_reset_out,
  output logic             is_slave_out
);
  // Synchronised pins: {cs0, cs1, da[2:0], rd, wr, cable}.
  logic [7:0]  pins_s;
  logic [15:0] data_s;
  atf_strobe_sync #(.W(8)) u_pin_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .async_in ({command_block_select_n_in, control_block_select_n_in,
                register_address_lines_in, host_read_strobe_n_in,
                host_write_strobe_n_in, cable_select_in}),
    .sync_out (pins_s)
  );
  atf_strobe_sync #(.W(16)) u_dat_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ce_in    (ce_in),
    .async_in (host_data_in),
    .sync_out (data_s)
  );
  logic       cs0_n, cs1_n, rd_n, wr_n, cab;
  logic [2:0] da;
  assign cs0_n = pins_s[7];
  assign cs1_n = pins_s[6];
  assign da    = pins_s[5:3];
  assign rd_n  = pins_s[2];
  assign wr_n  = pins_s[1];
  assign cab   = pins_s[0];

  typedef struct packed {
    atf_state_t  st;
    atf_sel_t    sel;
    logic [2:0]  ofs;
    logic [7:0]  feat;
    logic [7:0]  scnt;
    logic [7:0]  snum;
    logic [7:0]  cyllo;
    logic [7:0]  cylhi;
    logic [7:0]  devhead;
    logic [7:0]  cmd;
    logic [7:0]  dctl;
    logic        irq_pend;
    logic        slave;
    logic [1:0]  strap_cnt;
    logic [15:0] dout;
    logic [15:0] doe;
    logic        intrq;
    logic        rd_pop;
    logic        wr_push;
    logic [15:0] wdata;
    logic        start;
  } atf_state_s_t;
  atf_state_s_t s_reg, s_next;

  logic [7:0] drive_addr;
  logic       selected;
  atf_sel_t   sel_now;
  always_comb begin
    // Chip select decode: one selects a block, both is invalid.
    unique case ({~cs1_n, ~cs0_n})
      2'b01:   sel_now = ATF_SEL_CMD;
      2'b10:   sel_now = ATF_SEL_CTL;
      2'b11:   sel_now = ATF_SEL_BAD;
      default: sel_now = ATF_SEL_NONE;
    endcase
  end
  // Selected when the device select bit matches its role; this gates only the interrupt and the drive address flags.
  assign selected = (s_reg.devhead[`ATF_DH_DEV] == s_reg.slave);
  always_comb begin
    drive_addr = 8'h00;
    drive_addr[`ATF_DA_FLOAT] = 1'b1;
    drive_addr[`ATF_DA_WGATE] = ~core_disk_write_in;
    drive_addr[5:2] = ~s_reg.devhead[3:0];
    drive_addr[1] = ~(selected & s_reg.slave);
    drive_addr[0] = ~(selected & ~s_reg.slave);
  end

  always_comb begin
    s_next = s_reg;
    s_next.rd_pop  = 1'b0;
    s_next.wr_push = 1'b0;
    s_next.start   = 1'b0;
    // Keep sampling the strap until the cable select pin has crossed
    // both synchroniser stages, whose reset value would read as slave.
    if (s_reg.strap_cnt != 2'h3) begin
      s_next.slave     = jumper_fitted_in & cab;
      s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
    end
    // Command end reload of address registers; the head field follows.
    if (core_done_in) begin
      s_next.snum  = core_sector_in;
      s_next.cyllo = core_cyl_in[7:0];
      s_next.cylhi = core_cyl_in[15:8];
      s_next.devhead[3:0] = core_head_in;
    end
    // Set wins over acknowledge.
    if (core_irq_in)
      s_next.irq_pend = 1'b1;
    case (s_reg.st)
      ATF_ST_IDLE: begin
        if (!rd_n && wr_n) begin
          s_next.st  = ATF_ST_RD;
          s_next.sel = sel_now;
          s_next.ofs = da;
          s_next.doe = 16'h0000;
          if (sel_now == ATF_SEL_CMD) begin
            s_next.doe = 16'h00FF;
            case (da)
              `ATF_OFS_DATA: begin
                // Drive the data port only while data is requested.
                if (core_status_in[`ATF_ST_DREQ]) begin
                  s_next.dout = core_rd_data_in;
                  s_next.doe  = core_byte_mode_in ? 16'h00FF
                                                  : 16'hFFFF;
                end else begin
                  s_next.doe  = 16'h0000;
                end
              end
              `ATF_OFS_ERRFEAT: s_next.dout = {8'h00, core_error_in};
              `ATF_OFS_SECCNT:  s_next.dout = {8'h00, s_reg.scnt};
              `ATF_OFS_SECNUM:  s_next.dout = {8'h00, s_reg.snum};
              `ATF_OFS_CYLLO:   s_next.dout = {8'h00, s_reg.cyllo};
              `ATF_OFS_CYLHI:   s_next.dout = {8'h00, s_reg.cylhi};
              `ATF_OFS_DEVHEAD: s_next.dout = {8'h00, s_reg.devhead};
              default: begin
                s_next.dout = {8'h00, core_status_in};
                if (!core_irq_in)
                  s_next.irq_pend = 1'b0;
              end
            endcase
          end else if (sel_now == ATF_SEL_CTL) begin
            if (da == `ATF_OFS_ALTCTL) begin
              s_next.dout = {8'h00, core_status_in};
              s_next.doe  = 16'h00FF;
            end else if (da == `ATF_OFS_DRVADDR) begin
              s_next.dout = {8'h00, drive_addr};
              s_next.doe  = 16'h007F;
            end
          end
        end else if (!wr_n && rd_n) begin
          s_next.st  = ATF_ST_WR;
          s_next.sel = sel_now;
          s_next.ofs = da;
        end
      end
      ATF_ST_RD: begin
        if (rd_n) begin
          s_next.st  = ATF_ST_IDLE;
          s_next.doe = 16'h0000;
          if (s_reg.sel == ATF_SEL_CMD && s_reg.ofs == `ATF_OFS_DATA &&
              s_reg.doe != 16'h0000)
            s_next.rd_pop = 1'b1;
        end
      end
      ATF_ST_WR: begin
        // Latch on release, with the data that was set up before it.
        if (wr_n) begin
          s_next.st = ATF_ST_IDLE;
          if (s_reg.sel == ATF_SEL_CMD) begin
            case (s_reg.ofs)
              `ATF_OFS_DATA: begin
                s_next.wr_push = 1'b1;
                s_next.wdata   = data_s;
              end
              `ATF_OFS_ERRFEAT: s_next.feat    = data_s[7:0];
              `ATF_OFS_SECCNT:  s_next.scnt    = data_s[7:0];
              `ATF_OFS_SECNUM:  s_next.snum    = data_s[7:0];
              `ATF_OFS_CYLLO:   s_next.cyllo   = data_s[7:0];
              `ATF_OFS_CYLHI:   s_next.cylhi   = data_s[7:0];
              `ATF_OFS_DEVHEAD: s_next.devhead = data_s[7:0];
              default: begin
                s_next.cmd   = data_s[7:0];
                s_next.start = 1'b1;
              end
            endcase
          end else if (s_reg.sel == ATF_SEL_CTL &&
                       s_reg.ofs == `ATF_OFS_ALTCTL) begin
            s_next.dctl = data_s[7:0];
          end
        end
      end
      default: s_next.st = ATF_ST_IDLE;
    endcase
    // Interrupt line gated by disable bit and selection.
    s_next.intrq = s_reg.irq_pend & ~s_reg.dctl[`ATF_DC_IDIS] &
                   selected;
    // Soft reset reinitialises the task file except features and command, and keeps device control.
    if (s_reg.dctl[`ATF_DC_RESET]) begin
      s_next.scnt     = `ATF_RST_SECCNT;
      s_next.snum     = `ATF_RST_SECNUM;
      s_next.cyllo    = `ATF_RST_CYLLO;
      s_next.cylhi    = `ATF_RST_CYLHI;
      s_next.devhead  = `ATF_RST_DEVHEAD;
      s_next.irq_pend = 1'b0;
      s_next.start    = 1'b0;
      s_next.wr_push  = 1'b0;
      s_next.intrq    = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_reg <= '{st: ATF_ST_IDLE, sel: ATF_SEL_NONE, ofs: 3'h0,
                 feat: `ATF_RST_FEAT, scnt: `ATF_RST_SECCNT,
                 snum: `ATF_RST_SECNUM, cyllo: `ATF_RST_CYLLO,
                 cylhi: `ATF_RST_CYLHI, devhead: `ATF_RST_DEVHEAD,
                 cmd: 8'h00, dctl: `ATF_RST_DCTL, irq_pend: 1'b0,
                 slave: 1'b0, strap_cnt: 2'h0, dout: 16'h0000,
                 doe: 16'h0000, intrq: 1'b0, rd_pop: 1'b0,
                 wr_push: 1'b0, wdata: 16'h0000, start: 1'b0};
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  assign host_data_out    = s_reg.dout;
  assign host_data_oe_out = s_reg.doe;
  assign host_intrq_out   = s_reg.intrq;
  assign core_rd_pop_out  = s_reg.rd_pop;
  assign core_wr_push_out = s_reg.wr_push;
  assign core_wr_data_out = s_reg.wdata;
  assign cmd_start_out    = s_reg.start;
  assign cmd_code_out     = s_reg.cmd;
  assign features_out     = s_reg.feat;
  assign sector_count_out = s_reg.scnt;
  assign lba_mode_out     = s_reg.devhead[`ATF_DH_LBA];
  assign lba_out          = {s_reg.devhead[3:0], s_reg.cylhi,
                             s_reg.cyllo, s_reg.snum};
  assign device_reset_out = s_reg.dctl[`ATF_DC_RESET];
  assign is_slave_out     = s_reg.slave;

  // Checks.
  sequence s_cmd_write;
    s_reg.st == ATF_ST_WR && wr_n && s_reg.sel == ATF_SEL_CMD &&
    s_reg.ofs == `ATF_OFS_STATCMD && !s_reg.dctl[`ATF_DC_RESET] && ce_in;
  endsequence
  property p_cmd_start;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_cmd_write |=> cmd_start_out && cmd_code_out == $past(data_s[7:0]);
  endproperty
  a_cmd_start: assert property (p_cmd_start)
    else $error("command write did not start command");
  property p_float_unsel;
    @(posedge clk_in) disable iff (!rst_n_in)
      (s_reg.st == ATF_ST_IDLE && !rd_n && wr_n && ce_in &&
       (cs0_n == cs1_n)) |=> host_data_oe_out == 16'h0000;
  endproperty
  a_float_unsel: assert property (p_float_unsel)
    else $error("bus driven without valid select");
  property p_top_float;
    @(posedge clk_in) disable iff (!rst_n_in)
      host_data_oe_out[7] |-> !(s_reg.sel == ATF_SEL_CTL &&
                                s_reg.ofs == `ATF_OFS_DRVADDR);
  endproperty
  a_top_float: assert property (p_top_float)
    else $error("drive address top bit driven");
  property p_intr_gate;
    @(posedge clk_in) disable iff (!rst_n_in)
      host_intrq_out |-> $past(s_reg.irq_pend && selected &&
                               !s_reg.dctl[`ATF_DC_IDIS]);
  endproperty
  a_intr_gate: assert property (p_intr_gate)
    else $error("interrupt raised while disabled");
  property p_reset_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
      (s_reg.dctl[`ATF_DC_RESET] && ce_in) |=>
        !cmd_start_out && sector_count_out == `ATF_RST_SECCNT;
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("soft reset did not hold device");
  property p_done_cyl;
    @(posedge clk_in) disable iff (!rst_n_in)
      (core_done_in && ce_in && !s_reg.dctl[`ATF_DC_RESET]) |=>
        lba_out[23:8] == $past(core_cyl_in);
  endproperty
  a_done_cyl: assert property (p_done_cyl)
    else $error("cylinder not updated at command end");
  property p_drq_data;
    @(posedge clk_in) disable iff (!rst_n_in)
      (host_data_oe_out[15] && s_reg.st == ATF_ST_RD) |->
        s_reg.sel == ATF_SEL_CMD && s_reg.ofs == `ATF_OFS_DATA;
  endproperty
  a_drq_data: assert property (p_drq_data)
    else $error("upper byte driven outside data register");
  property p_alt_noack;
    @(posedge clk_in) disable iff (!rst_n_in)
      (s_reg.st == ATF_ST_IDLE && !rd_n && wr_n && ce_in &&
       sel_now == ATF_SEL_CTL && s_reg.irq_pend &&
       !s_reg.dctl[`ATF_DC_RESET]) |=> s_reg.irq_pend;
  endproperty
  a_alt_noack: assert property (p_alt_noack)
    else $error("alternate status cleared interrupt");
endmodule // atf_task_file
`default_nettype wire

// >>> tb/atf_host_model.sv
// Purpose: Host controller model driving the task file pins.
// Assumes: Pins change on the falling clock edge only.
// Notes:   Strobes last six cycles with four cycles of recovery.
`timescale 1ns/10ps
`default_nettype none
module atf_host_model
  import atf_pkg::*;
(
  // Clock
  input  wire logic        clk_in,
  // Read return
  input  wire logic [15:0] host_data_in,
  input  wire logic [15:0] host_oe_in,
  // Host pins
  output logic             command_block_select_n_out,
  output logic             control_block_select_n_out,
  output logic [2:0]       register_address_lines_out,
  output logic             host_read_strobe_n_out,
  output logic             host_write_strobe_n_out,
  output logic [15:0]      host_data_out
);
  initial begin
    command_block_select_n_out = 1'b1;
    control_block_select_n_out = 1'b1;
    register_address_lines_out = 3'h0;
    host_read_strobe_n_out = 1'b1;
    host_write_strobe_n_out = 1'b1;
    host_data_out = 16'h0000;
  end

  task automatic setup(input atf_sel_t sel, input logic [2:0] ofs);
    @(negedge clk_in);
    command_block_select_n_out = ~sel[0];
    control_block_select_n_out = ~sel[1];
    register_address_lines_out = ofs;
    @(negedge clk_in);
  endtask

  task automatic finish_cycle();
    @(negedge clk_in);
    command_block_select_n_out = 1'b1;
    control_block_select_n_out = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask

  task automatic bus_read(input atf_sel_t sel, input logic [2:0] ofs,
                          output logic [15:0] dat, output logic [15:0] oe);
    setup(sel, ofs);
    host_read_strobe_n_out = 1'b0;
    repeat (6) @(negedge clk_in);
    dat = host_data_in;
    oe = host_oe_in;
    host_read_strobe_n_out = 1'b1;
    finish_cycle();
  endtask

  // Whole 16-bit words always go out; the design keeps what it needs.
  task automatic bus_write(input atf_sel_t sel, input logic [2:0] ofs,
                           input logic [15:0] dat);
    setup(sel, ofs);
    host_data_out = dat;
    host_write_strobe_n_out = 1'b0;
    repeat (6) @(negedge clk_in);
    host_write_strobe_n_out = 1'b1;
    repeat (3) @(negedge clk_in);
    // A released bus must not look like it still holds the word.
    host_data_out = ~dat;
    finish_cycle();
  endtask
endmodule // atf_host_model
`default_nettype wire

// >>> tb/tb_ata_task_file_register_decode.sv
// Purpose: Self-checking bench for the task file register decode.
// Assumes: Host model owns all host pins; bench drives the core side.
// Notes:   Random values come from a fixed seed.
`timescale 1ns/10ps
`default_nettype none
module tb_ata_task_file_register_decode;
  import atf_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cs0_n, cs1_n, rd_n, wr_n, bm, irq, done, dw, jmp, csel;
  logic intrq, pop, push, cstart, lmode, dres, slv;
  logic [2:0]  ofs;
  logic [3:0]  hd4, h;
  logic [7:0]  st, er, sec, code, feat, scnt;
  logic [7:0]  v [2:5];
  logic [15:0] hd, dout, doe, rdd, cyl, wdat, rdat, roe, w;
  logic [27:0] lba;
  int err_count = 0, check_count = 0, seed = 76910, cyc = 0;
  int n_start = 0, n_push = 0, n_pop = 0, n0;

  atf_task_file atf_task_file_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(1'b1), .command_block_select_n_in(cs0_n),
    .control_block_select_n_in(cs1_n), .register_address_lines_in(ofs),
    .host_read_strobe_n_in(rd_n), .host_write_strobe_n_in(wr_n),
    .host_data_in(hd), .host_data_out(dout), .host_data_oe_out(doe),
    .host_intrq_out(intrq), .jumper_fitted_in(jmp), .cable_select_in(csel),
    .core_status_in(st), .core_error_in(er), .core_rd_data_in(rdd),
    .core_byte_mode_in(bm), .core_irq_in(irq), .core_done_in(done),
    .core_sector_in(sec), .core_cyl_in(cyl), .core_head_in(hd4),
    .core_disk_write_in(dw), .core_rd_pop_out(pop),
    .core_wr_push_out(push), .core_wr_data_out(wdat),
    .cmd_start_out(cstart), .cmd_code_out(code), .features_out(feat),
    .sector_count_out(scnt), .lba_mode_out(lmode), .lba_out(lba),
    .device_reset_out(dres), .is_slave_out(slv));

  atf_host_model atf_host_model_inst (.clk_in(clk_in), .host_data_in(dout),
    .host_oe_in(doe), .command_block_select_n_out(cs0_n),
    .control_block_select_n_out(cs1_n), .register_address_lines_out(ofs),
    .host_read_strobe_n_out(rd_n), .host_write_strobe_n_out(wr_n),
    .host_data_out(hd));

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  // Pulses are counted mid-cycle, well away from the edge that moves them.
  always @(negedge clk_in) begin
    cyc++;
    if (cstart === 1'b1) n_start++;
    if (push === 1'b1) n_push++;
    if (pop === 1'b1) n_pop++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  function automatic logic [15:0] da_exp(logic [7:0] dh, logic wg, logic sl);
    logic sel;
    sel = (dh[4] == sl);
    return {9'h000, ~wg, ~dh[3:0], ~(sl & sel), ~(~sl & sel)};
  endfunction

  function automatic logic [27:0] lba_exp(logic [7:0] dh, logic [7:0] hi,
                                         logic [7:0] lo, logic [7:0] sn);
    return {dh[3:0], hi, lo, sn};
  endfunction

  task automatic chk16(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic rd(input atf_sel_t s, input logic [2:0] o);
    atf_host_model_inst.bus_read(s, o, rdat, roe);
  endtask

  task automatic wr(input atf_sel_t s, input logic [2:0] o,
                    input logic [15:0] d);
    atf_host_model_inst.bus_write(s, o, d);
  endtask

  task automatic pulse(input logic is_done);
    @(negedge clk_in);
    if (is_done) done = 1'b1;
    else irq = 1'b1;
    @(negedge clk_in);
    done = 1'b0;
    irq = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask

  task automatic do_reset();
    @(negedge clk_in);
    rst_n_in = 1'b0;
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
  endtask

  task automatic final_report();
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {bm, irq, done, dw, jmp, csel} = 6'h00;
    st = 8'h50;
    er = 8'h01;
    sec = 8'h00;
    cyl = 16'h0000;
    hd4 = 4'h0;
    rdd = 16'h0000;
    do_reset();
    for (int i = 2; i < 6; i++) begin
      rd(ATF_SEL_CMD, 3'(i));
      chk16("default", (i < 4) ? 16'h0001 : 16'h0000, rdat & 16'h00FF);
    end
    for (int i = 2; i < 6; i++) begin
      v[i] = 8'($random(seed));
      wr(ATF_SEL_CMD, 3'(i), {8'h00, v[i]});
    end
    for (int i = 2; i < 6; i++) begin
      rd(ATF_SEL_CMD, 3'(i));
      chk16("readback", {8'h00, v[i]}, rdat & 16'h00FF);
    end
    h = 4'($random(seed));
    wr(ATF_SEL_CMD, 3'h6, {12'h00E, h});
    chk1("lba mode", 1'b1, lmode);
    chk16("lba low", 16'(lba_exp({4'hE, h}, v[5], v[4], v[3])),
          lba[15:0]);
    chk16("lba high", 16'(lba_exp({4'hE, h}, v[5], v[4], v[3]) >> 16),
          16'(lba >> 16));
    wr(ATF_SEL_CMD, 3'h6, {12'h00A, h});
    chk1("chs mode", 1'b0, lmode);
    w = 16'($random(seed));
    wr(ATF_SEL_CMD, 3'h1, w);
    chk16("features", {8'h00, w[7:0]}, {8'h00, feat});
    n0 = n_start;
    wr(ATF_SEL_CMD, 3'h7, 16'h0020);
    chk16("starts", 16'h0001, 16'(n_start - n0));
    chk16("code", 16'h0020, {8'h00, code});
    st = 8'($random(seed)) | 8'h08;
    er = 8'($random(seed));
    rd(ATF_SEL_CMD, 3'h1);
    chk16("error", {8'h00, er}, rdat & 16'h00FF);
    rd(ATF_SEL_CTL, 3'h6);
    chk16("alt status", {8'h00, st}, rdat & 16'h00FF);
    wr(ATF_SEL_CTL, 3'h6, 16'h0000);
    pulse(1'b0);
    chk1("irq raised", 1'b1, intrq);
    rd(ATF_SEL_CTL, 3'h6);
    chk1("irq after alt", 1'b1, intrq);
    rd(ATF_SEL_CMD, 3'h7);
    chk16("status", {8'h00, st}, rdat & 16'h00FF);
    chk1("irq acked", 1'b0, intrq);
    pulse(1'b0);
    wr(ATF_SEL_CTL, 3'h6, 16'h0002);
    chk1("irq masked", 1'b0, intrq);
    wr(ATF_SEL_CTL, 3'h6, 16'h0000);
    chk1("irq unmasked", 1'b1, intrq);
    wr(ATF_SEL_CMD, 3'h6, {12'h00B, h});
    chk1("irq other dev", 1'b0, intrq);
    for (int k = 0; k < 2; k++) begin
      dw = k[0];
      rd(ATF_SEL_CTL, 3'h7);
      chk16("addr oe", 16'h007F, roe);
      chk16("addr", da_exp({4'hB, h}, dw, 1'b0), rdat & 16'h007F);
    end
    rd(ATF_SEL_CMD, 3'h7);
    wr(ATF_SEL_CMD, 3'h6, {12'h00A, h});
    rd(ATF_SEL_CTL, 3'h7);
    chk16("addr sel", da_exp({4'hA, h}, dw, 1'b0),
          rdat & 16'h007F);
    for (int k = 0; k < 3; k++) begin
      rdd = 16'($random(seed));
      bm = (k == 1);
      st[3] = (k != 2);
      n0 = n_pop;
      rd(ATF_SEL_CMD, 3'h0);
      chk16("pops", (k < 2) ? 16'h0001 : 16'h0000, 16'(n_pop - n0));
      chk16("data oe", (k == 0) ? 16'hFFFF : (k == 1) ? 16'h00FF : 16'h0000,
            roe);
      if (k == 0) chk16("data", rdd, rdat);
    end
    n0 = n_push;
    w = 16'($random(seed));
    wr(ATF_SEL_CMD, 3'h0, w);
    chk16("pushes", 16'h0001, 16'(n_push - n0));
    chk16("push data", w, wdat);
    for (int i = 0; i < 6; i++) begin
      rd(ATF_SEL_CTL, 3'(i));
      chk16("ctl float", 16'h0000, roe);
    end
    rd(ATF_SEL_NONE, 3'h7);
    chk16("none float", 16'h0000, roe);
    rd(ATF_SEL_BAD, 3'h7);
    chk16("both float", 16'h0000, roe);
    wr(ATF_SEL_BAD, 3'h2, 16'h0055);
    wr(ATF_SEL_NONE, 3'h2, 16'h0066);
    wr(ATF_SEL_CTL, 3'h2, 16'h0077);
    rd(ATF_SEL_CMD, 3'h2);
    chk16("ignored", {8'h00, v[2]}, rdat & 16'h00FF);
    sec = 8'($random(seed));
    cyl = 16'($random(seed));
    hd4 = 4'($random(seed));
    pulse(1'b1);
    rd(ATF_SEL_CMD, 3'h4);
    chk16("end cyl lo", {8'h00, cyl[7:0]}, rdat & 16'h00FF);
    rd(ATF_SEL_CMD, 3'h5);
    chk16("end cyl hi", {8'h00, cyl[15:8]}, rdat & 16'h00FF);
    rd(ATF_SEL_CMD, 3'h6);
    chk16("end head", {12'h000, hd4}, rdat & 16'h000F);
    wr(ATF_SEL_CTL, 3'h6, 16'h0004);
    chk1("soft reset", 1'b1, dres);
    repeat (200) @(negedge clk_in);
    rd(ATF_SEL_CMD, 3'h2);
    chk16("reset count", 16'h0001, rdat & 16'h00FF);
    wr(ATF_SEL_CTL, 3'h6, 16'h0000);
    chk1("reset off", 1'b0, dres);
    wr(ATF_SEL_CMD, 3'h2, 16'h0033);
    chk16("count out", 16'h0033, {8'h00, scnt});
    for (int j = 0; j < 3; j++) begin
      jmp = (j != 0);
      csel = (j != 1);
      do_reset();
      chk1("slave", j == 2, slv);
    end
    final_report();
  end
endmodule // tb_ata_task_file_register_decode
`default_nettype wire
